// ==== verilog/smm_window_control.sv ====
// smm ram window control: control register, lock, error flag and cycle steering
`timescale 1ns/1ns
module smm_window_control
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // configuration access
  input wire smm_window_pkg::cfg_write_s cfg_wr,
  input wire logic [7:0] cfg_rd_offset,
  output logic [7:0] cfg_rd_data,
  // memory size from the row-population logic
  input wire logic [31:0] top_of_memory,
  // host memory cycle
  input wire smm_window_pkg::host_cycle_s host_cycle,
  // steering result, registered
  output smm_window_pkg::dest_e cycle_dest,
  output logic cycle_dest_valid,
  output logic cycle_write_blocked,
  // control levels to the rest of the controller
  output logic [1:0] graphics_mode_select,
  output logic row_population_read_only,
  output logic extended_smm_access_error
);

  logic [1:0] gms_q;
  logic [1:0] upper_q;
  logic [1:0] lower_q;
  logic lock_q;
  logic err_q;
  logic ctrl_hit;
  logic [7:0] wdata;
  logic err_event;
  logic err_clear;
  smm_window_pkg::dest_e dest_c;
  logic hits_ext_c;
  logic blocked_c;
  smm_window_pkg::dest_e dest_q;
  logic dest_valid_q;
  logic blocked_q;

  assign ctrl_hit = cfg_wr.wr && (cfg_wr.offset == smm_window_pkg::SMM_CTRL_OFFSET);
  assign wdata = cfg_wr.data;

  // lock bit: sticky once written to one, only reset clears it
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      lock_q <= smm_window_pkg::SMM_CTRL_RESET[smm_window_pkg::LOCK_BIT];
    else if (ctrl_hit && wdata[smm_window_pkg::LOCK_BIT])
      lock_q <= 1'b1;
  end

  // graphics mode and upper select freeze once locked
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gms_q <= smm_window_pkg::SMM_CTRL_RESET[smm_window_pkg::GFX_MODE_HI:smm_window_pkg::GFX_MODE_LO];
      upper_q <= smm_window_pkg::SMM_CTRL_RESET[smm_window_pkg::UPPER_SEL_HI:smm_window_pkg::UPPER_SEL_LO];
    end
    else if (ctrl_hit && !lock_q)
    begin
      gms_q <= wdata[smm_window_pkg::GFX_MODE_HI:smm_window_pkg::GFX_MODE_LO];
      upper_q <= wdata[smm_window_pkg::UPPER_SEL_HI:smm_window_pkg::UPPER_SEL_LO];
    end
  end

  // lower select: msb frozen by lock, lsb stays writable while the msb holds one
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      lower_q <= smm_window_pkg::SMM_CTRL_RESET[smm_window_pkg::LOWER_SEL_HI:smm_window_pkg::LOWER_SEL_LO];
    else if (ctrl_hit)
    begin
      if (!lock_q)
        lower_q <= wdata[smm_window_pkg::LOWER_SEL_HI:smm_window_pkg::LOWER_SEL_LO];
      else if (lower_q[1])
        lower_q[0] <= wdata[smm_window_pkg::LOWER_SEL_LO];
    end
  end

  // route decode of the presented cycle
  smm_route_decode u_decode
  (
    .upper_smm_select(upper_q),
    .lower_smm_select(lower_q),
    .gfx_enabled(gms_q != 2'h0),
    .top_of_memory(top_of_memory),
    .cyc(host_cycle),
    .dest(dest_c),
    .hits_extended(hits_ext_c),
    .write_blocked(blocked_c)
  );

  // error source: processor outside smm in extended ranges, write-backs excluded
  assign err_event = host_cycle.valid && hits_ext_c && host_cycle.from_cpu
                     && !host_cycle.smm && !host_cycle.write_back;
  assign err_clear = ctrl_hit && wdata[smm_window_pkg::ERR_BIT];

  // sticky error flag; a new event in the clearing cycle wins
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      err_q <= smm_window_pkg::SMM_CTRL_RESET[smm_window_pkg::ERR_BIT];
    else if (err_event)
      err_q <= 1'b1;
    else if (err_clear)
      err_q <= 1'b0;
  end

  // registered steering result, one cycle after the cycle is presented
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dest_q <= smm_window_pkg::DEST_HUB;
      dest_valid_q <= 1'b0;
      blocked_q <= 1'b0;
    end
    else
    begin
      dest_valid_q <= host_cycle.valid;
      if (host_cycle.valid)
      begin
        dest_q <= dest_c;
        blocked_q <= blocked_c;
      end
    end
  end

  // read mux; other offsets belong to other registers and read zero here
  always_comb
  begin
    cfg_rd_data = 8'h00;
    if (cfg_rd_offset == smm_window_pkg::SMM_CTRL_OFFSET)
      cfg_rd_data = {gms_q, upper_q, lower_q, lock_q, err_q};
  end

  assign cycle_dest = dest_q;
  assign cycle_dest_valid = dest_valid_q;
  assign cycle_write_blocked = blocked_q;
  assign graphics_mode_select = gms_q;
  assign row_population_read_only = lock_q;
  assign extended_smm_access_error = err_q;

  // sequence of a locking write
  sequence lock_write_s;
    ctrl_hit && wdata[smm_window_pkg::LOCK_BIT];
  endsequence

  // a host cycle taken at this edge
  sequence cycle_taken_s;
    host_cycle.valid;
  endsequence

  // a taken cycle in the legacy segment, outside the extended ranges, under a further condition
  sequence ab_hit_s(cond);
    host_cycle.valid && !hits_ext_c && cond
    && host_cycle.addr >= smm_window_pkg::AB_SEG_BASE && host_cycle.addr <= smm_window_pkg::AB_SEG_LAST;
  endsequence

  // lock and field freezing
  chk_lock_sticks: assert property (@(posedge ref_clk) disable iff (!rst_n)
    lock_write_s |=> lock_q [*8])
    else $error("lock bit did not stay set");

  chk_lock_not_cleared: assert property (@(posedge ref_clk) disable iff (!rst_n)
    lock_q |=> lock_q)
    else $error("lock bit cleared without reset");

  chk_lock_by_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!lock_q && !(ctrl_hit && wdata[smm_window_pkg::LOCK_BIT])) |=> !lock_q)
    else $error("lock bit set without a locking write");

  chk_upper_frozen: assert property (@(posedge ref_clk) disable iff (!rst_n)
    lock_q |=> $stable(upper_q) && $stable(gms_q))
    else $error("upper or graphics field changed while locked");

  chk_lower_msb_frozen: assert property (@(posedge ref_clk) disable iff (!rst_n)
    lock_q |=> $stable(lower_q[1]))
    else $error("lower msb changed while locked");

  chk_unlocked_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ctrl_hit && !lock_q) |=> {gms_q, upper_q, lower_q} == ($past(wdata) >> smm_window_pkg::LOWER_SEL_LO))
    else $error("unlocked write did not land");

  chk_lower_lsb_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (lock_q && !lower_q[1]) |=> $stable(lower_q[0]))
    else $error("lower lsb changed while locked with msb clear");

  chk_lsb_write_locked: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ctrl_hit && lock_q && lower_q[1]) |=> {lower_q, 2'h0} == (($past(wdata) & 8'h04) | 8'h08))
    else $error("lower lsb not written while locked with msb set");

  chk_row_lock: assert property (@(posedge ref_clk) disable iff (!rst_n)
    lock_write_s |=> row_population_read_only)
    else $error("row population not locked");

  // error flag
  chk_error_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
    err_event |=> err_q)
    else $error("error flag not set by non-smm extended access");

  chk_error_rises_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!err_q && !err_event) |=> !err_q)
    else $error("error flag set without an offending cycle");

  chk_error_holds: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (err_q && !err_clear) |=> err_q)
    else $error("error flag dropped without clearing write");

  chk_error_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (err_clear && !err_event) |=> !err_q)
    else $error("error flag not cleared by writing one");

  chk_error_writeback: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!err_q && host_cycle.write_back && !(host_cycle.valid && hits_ext_c && !host_cycle.smm
     && !host_cycle.write_back && host_cycle.from_cpu)) |=> !err_q)
    else $error("error flag set by write-back cycle");

  // window decode
  chk_upper_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (upper_q == smm_window_pkg::UPPER_OFF) |-> !hits_ext_c)
    else $error("extended range hit with upper field off");

  chk_top_1m_base: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (upper_q == smm_window_pkg::UPPER_TOP_1M
     && host_cycle.addr == top_of_memory - smm_window_pkg::TOP_SIZE_1M) |-> hits_ext_c)
    else $error("top region base missed at 1m size");

  chk_top_below_512k: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (upper_q == smm_window_pkg::UPPER_TOP_512K && host_cycle.addr < smm_window_pkg::HIGH_REMAP_BASE
     && host_cycle.addr == top_of_memory - smm_window_pkg::TOP_SIZE_512K - 32'h00000001) |-> !hits_ext_c)
    else $error("address below top region hit at 512k size");

  chk_top_end_excl: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (upper_q[1] && host_cycle.addr == top_of_memory && host_cycle.addr < smm_window_pkg::HIGH_REMAP_BASE)
    |-> !hits_ext_c)
    else $error("top of memory itself inside top region");

  chk_remap_alias: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (upper_q != smm_window_pkg::UPPER_OFF && lower_q == smm_window_pkg::LOWER_DISABLED
     && host_cycle.addr >= smm_window_pkg::HIGH_REMAP_BASE && host_cycle.addr <= smm_window_pkg::HIGH_REMAP_LAST)
    |-> hits_ext_c)
    else $error("high remap window not decoded");

  chk_remap_needs_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (host_cycle.valid && lower_q != smm_window_pkg::LOWER_DISABLED
     && host_cycle.addr >= smm_window_pkg::HIGH_REMAP_BASE && host_cycle.addr <= smm_window_pkg::HIGH_REMAP_LAST)
    |-> !hits_ext_c || (upper_q[1] && host_cycle.addr < top_of_memory))
    else $error("high remap enabled with lower field nonzero");

  // steering of taken cycles
  chk_answer_latency: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cycle_taken_s |=> cycle_dest_valid)
    else $error("steering result missing one cycle after a taken cycle");

  chk_no_spurious_answer: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !host_cycle.valid |=> !cycle_dest_valid)
    else $error("steering result without a taken cycle");

  chk_dest_onehot: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cycle_dest_valid |-> $onehot(cycle_dest))
    else $error("destination not one-hot");

  chk_top_smm_dram: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (host_cycle.valid && hits_ext_c && host_cycle.smm && host_cycle.from_cpu)
    |=> cycle_dest == smm_window_pkg::DEST_DRAM)
    else $error("processor smm cycle in extended range not sent to dram");

  chk_ext_to_hub: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (host_cycle.valid && hits_ext_c && !host_cycle.smm) |=> cycle_dest == smm_window_pkg::DEST_HUB)
    else $error("non-smm extended access not sent to hub");

  chk_ab_disabled: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (host_cycle.valid && host_cycle.write && !hits_ext_c && lower_q == smm_window_pkg::LOWER_DISABLED
     && host_cycle.addr >= smm_window_pkg::AB_SEG_BASE && host_cycle.addr <= smm_window_pkg::AB_SEG_LAST)
    |=> cycle_write_blocked && cycle_dest != smm_window_pkg::DEST_DRAM)
    else $error("write reached disabled legacy segment");

  chk_blocked_only_disabled: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (host_cycle.valid && lower_q != smm_window_pkg::LOWER_DISABLED) |=> !cycle_write_blocked)
    else $error("write blocked with legacy segment enabled");

  chk_system_ram: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ab_hit_s(lower_q == smm_window_pkg::LOWER_SYSTEM_RAM)
    |=> cycle_dest == smm_window_pkg::DEST_DRAM && !cycle_write_blocked)
    else $error("legacy segment not plain system ram");

  chk_code_shadow: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ab_hit_s(lower_q == smm_window_pkg::LOWER_CODE_SHADOW
      && !(host_cycle.smm && host_cycle.from_cpu && host_cycle.code && !host_cycle.write))
    |=> cycle_dest != smm_window_pkg::DEST_DRAM)
    else $error("non-code cycle reached code shadow dram");

  chk_smm_ram_ab: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ab_hit_s(lower_q == smm_window_pkg::LOWER_SMM_RAM && host_cycle.smm && host_cycle.from_cpu)
    |=> cycle_dest == smm_window_pkg::DEST_DRAM)
    else $error("processor smm cycle not served by legacy dram");

  chk_ab_cpu_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ab_hit_s(lower_q[1] && !host_cycle.from_cpu) |=> cycle_dest != smm_window_pkg::DEST_DRAM)
    else $error("non-processor cycle reached legacy smm dram");

endmodule

// ==== verilog/smm_window_pkg.sv ====
// package: register layout, segment addresses and routing codes for the smm ram window control
package smm_window_pkg;

  // configuration register offset and reset value
  localparam logic [7:0] SMM_CTRL_OFFSET = 8'h70;
  localparam logic [7:0] SMM_CTRL_RESET = 8'h00;

  // field positions inside the control register
  localparam int GFX_MODE_HI = 7;
  localparam int GFX_MODE_LO = 6;
  localparam int UPPER_SEL_HI = 5;
  localparam int UPPER_SEL_LO = 4;
  localparam int LOWER_SEL_HI = 3;
  localparam int LOWER_SEL_LO = 2;
  localparam int LOCK_BIT = 1;
  localparam int ERR_BIT = 0;

  // upper select encodings
  localparam logic [1:0] UPPER_OFF = 2'h0;
  localparam logic [1:0] UPPER_HIGH_ONLY = 2'h1;
  localparam logic [1:0] UPPER_TOP_512K = 2'h2;
  localparam logic [1:0] UPPER_TOP_1M = 2'h3;

  // lower select encodings
  localparam logic [1:0] LOWER_DISABLED = 2'h0;
  localparam logic [1:0] LOWER_SYSTEM_RAM = 2'h1;
  localparam logic [1:0] LOWER_CODE_SHADOW = 2'h2;
  localparam logic [1:0] LOWER_SMM_RAM = 2'h3;

  // address ranges (32-bit host address)
  localparam logic [31:0] AB_SEG_BASE = 32'h000A0000;
  localparam logic [31:0] AB_SEG_LAST = 32'h000BFFFF;
  localparam logic [31:0] HIGH_REMAP_BASE = 32'hFEEA0000;
  localparam logic [31:0] HIGH_REMAP_LAST = 32'hFEEBFFFF;
  localparam logic [31:0] TOP_SIZE_512K = 32'h00080000;
  localparam logic [31:0] TOP_SIZE_1M = 32'h00100000;

  // destination of a host memory cycle
  typedef enum logic [2:0]
  {
    DEST_DRAM = 3'h1,
    DEST_GFX = 3'h2,
    DEST_HUB = 3'h4
  } dest_e;

  // one host memory cycle as presented for decode
  typedef struct packed
  {
    logic valid;
    logic [31:0] addr;
    logic smm;
    logic code;
    logic write;
    logic from_cpu;
    logic write_back;
  } host_cycle_s;

  // configuration write from the config space decoder
  typedef struct packed
  {
    logic wr;
    logic [7:0] offset;
    logic [7:0] data;
  } cfg_write_s;

endpackage

// ==== verilog/smm_route_decode.sv ====
// combinational decode of one host cycle against the current smm field values
`timescale 1ns/1ns
module smm_route_decode
(
  // current field values
  input wire logic [1:0] upper_smm_select,
  input wire logic [1:0] lower_smm_select,
  input wire logic gfx_enabled,
  input wire logic [31:0] top_of_memory,
  // cycle to steer
  input wire smm_window_pkg::host_cycle_s cyc,
  // verdict
  output smm_window_pkg::dest_e dest,
  output logic hits_extended,
  output logic write_blocked
);

  logic in_ab;
  logic in_high;
  logic in_top;
  logic high_en;
  logic top_en;
  logic [31:0] top_size;
  logic [31:0] top_base;

  // region enables; the high remap needs the lower field cleared as well
  assign high_en = (upper_smm_select != smm_window_pkg::UPPER_OFF)
                   && (lower_smm_select == smm_window_pkg::LOWER_DISABLED);
  assign top_en = upper_smm_select[1];
  assign top_size = (upper_smm_select == smm_window_pkg::UPPER_TOP_1M) ?
                    smm_window_pkg::TOP_SIZE_1M : smm_window_pkg::TOP_SIZE_512K;
  assign top_base = top_of_memory - top_size;

  // address windows
  assign in_ab = (cyc.addr >= smm_window_pkg::AB_SEG_BASE) && (cyc.addr <= smm_window_pkg::AB_SEG_LAST);
  assign in_high = high_en && (cyc.addr >= smm_window_pkg::HIGH_REMAP_BASE)
                   && (cyc.addr <= smm_window_pkg::HIGH_REMAP_LAST);
  assign in_top = top_en && (cyc.addr >= top_base) && (cyc.addr < top_of_memory);
  assign hits_extended = in_high || in_top;

  // steering of the cycle; legacy range falls to graphics when it is on, else hub
  always_comb
  begin
    dest = smm_window_pkg::DEST_DRAM;
    write_blocked = 1'b0;
    if (hits_extended)
    begin
      // only processor smm cycles may reach dram here
      if (!(cyc.smm && cyc.from_cpu))
        dest = smm_window_pkg::DEST_HUB;
    end
    else if (in_ab)
    begin
      unique case (lower_smm_select)
        smm_window_pkg::LOWER_DISABLED:
        begin
          dest = gfx_enabled ? smm_window_pkg::DEST_GFX : smm_window_pkg::DEST_HUB;
          write_blocked = cyc.write;
        end
        smm_window_pkg::LOWER_SYSTEM_RAM:
          dest = smm_window_pkg::DEST_DRAM;
        smm_window_pkg::LOWER_CODE_SHADOW:
        begin
          if (!(cyc.smm && cyc.from_cpu && cyc.code && !cyc.write))
            dest = gfx_enabled ? smm_window_pkg::DEST_GFX : smm_window_pkg::DEST_HUB;
        end
        smm_window_pkg::LOWER_SMM_RAM:
        begin
          if (!(cyc.smm && cyc.from_cpu))
            dest = gfx_enabled ? smm_window_pkg::DEST_GFX : smm_window_pkg::DEST_HUB;
        end
      endcase
    end
  end

endmodule

// ==== tb/host_bus_model.sv ====
// host processor bus model issuing smm-qualified memory cycles
`timescale 1ns/1ns
module host_bus_model
(
  // clock
  input wire logic ref_clk,
  // cycle toward the controller
  output smm_window_pkg::host_cycle_s host_cycle
);
  smm_window_pkg::host_cycle_s idle_c;

  // bus starts idle
  initial host_cycle = '0;

  // one cycle per edge, back to back when called in a row
  task automatic send(input smm_window_pkg::host_cycle_s c);
    @(posedge ref_clk);
    host_cycle <= c;
  endtask

  // released bus shows inverted leftovers, never a stale copy
  task automatic release_bus;
    @(posedge ref_clk);
    idle_c = ~host_cycle;
    idle_c.valid = 1'h0;
    host_cycle <= idle_c;
  endtask
endmodule

// ==== tb/smm_window_control_tb_top.sv ====
// self-checking bench for the smm ram window control
`timescale 1ns/1ns
module smm_window_control_tb_top;
  typedef struct packed
  {
    smm_window_pkg::dest_e dest;
    logic blk;
    logic err;
  } note_s;
  logic ref_clk = 1'h0;
  logic rst_n = 1'h0;
  smm_window_pkg::cfg_write_s cfg_wr = '0;
  logic [7:0] cfg_rd_offset = 8'h70;
  logic [7:0] cfg_rd_data;
  logic [31:0] top_of_memory = 32'h08000000;
  smm_window_pkg::host_cycle_s host_cycle;
  smm_window_pkg::dest_e cycle_dest;
  logic cycle_dest_valid;
  logic cycle_write_blocked;
  logic row_population_read_only;
  logic extended_smm_access_error;
  logic [1:0] graphics_mode_select;
  note_s notes[$];
  note_s got;
  int err_total = 0;
  int comparisons = 0;
  logic [7:0] cur_reg = 8'h00;
  logic [7:0] seed = 8'h3E;
  logic err_model = 1'h0;
  logic [31:0] sz;

  // free-running clock
  always #5 ref_clk = ~ref_clk;

  // shift register step for the random address offsets
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  smm_window_control smm_window_control_inst (.ref_clk(ref_clk), .rst_n(rst_n), .cfg_wr(cfg_wr),
    .cfg_rd_offset(cfg_rd_offset), .cfg_rd_data(cfg_rd_data), .top_of_memory(top_of_memory),
    .host_cycle(host_cycle), .cycle_dest(cycle_dest), .cycle_dest_valid(cycle_dest_valid),
    .cycle_write_blocked(cycle_write_blocked), .graphics_mode_select(graphics_mode_select),
    .row_population_read_only(row_population_read_only),
    .extended_smm_access_error(extended_smm_access_error));
  host_bus_model host_bus_model_inst (.ref_clk(ref_clk), .host_cycle(host_cycle));

  task automatic check(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'h1)
    begin
      $display("ERROR %0t %s", $time, msg);
      err_total++;
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic wr(input logic [7:0] off, input logic [7:0] d);
    @(posedge ref_clk);
    cfg_wr <= '{1'h1, off, d};
    @(posedge ref_clk);
    cfg_wr.wr <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] off, input logic [7:0] exp);
    @(posedge ref_clk);
    cfg_rd_offset <= off;
    @(negedge ref_clk);
    check(cfg_rd_data === exp, "register read");
  endtask

  // note the expected steering, then hand the cycle to the bus model
  task automatic issue(input logic [31:0] a, input logic [4:0] f);
    logic [1:0] l;
    logic smm;
    logic ab;
    logic hs;
    logic ts;
    note_s n;
    smm_window_pkg::dest_e off;
    smm_window_pkg::host_cycle_s c;
    c = smm_window_pkg::host_cycle_s'({1'h1, a, f});
    l = cur_reg[3:2];
    smm = c.smm & c.from_cpu;
    sz = cur_reg[4] ? smm_window_pkg::TOP_SIZE_1M : smm_window_pkg::TOP_SIZE_512K;
    off = (cur_reg[7:6] != 2'h0) ? smm_window_pkg::DEST_GFX : smm_window_pkg::DEST_HUB;
    ab = a >= smm_window_pkg::AB_SEG_BASE && a <= smm_window_pkg::AB_SEG_LAST;
    hs = cur_reg[5:4] != 2'h0 && l == 2'h0 && a >= smm_window_pkg::HIGH_REMAP_BASE
      && a <= smm_window_pkg::HIGH_REMAP_LAST;
    ts = cur_reg[5] && a >= top_of_memory - sz && a < top_of_memory;
    if (ab)
      n.dest = (l == 2'h1 || (l == 2'h3 && smm) || (l == 2'h2 && smm && c.code && !c.write))
        ? smm_window_pkg::DEST_DRAM : off;
    else if (hs || ts)
      n.dest = smm ? smm_window_pkg::DEST_DRAM : smm_window_pkg::DEST_HUB;
    else
      n.dest = smm_window_pkg::DEST_DRAM; // outside the smm windows the block leaves cycles on dram
    n.blk = ab && l == 2'h0 && c.write;
    err_model = err_model | (c.from_cpu & !c.smm & !c.write_back & (hs | ts));
    n.err = err_model;
    notes.push_back(n);
    host_bus_model_inst.send(c);
  endtask

  // results are compared against the oldest note
  always @(negedge ref_clk)
  begin
    if (cycle_dest_valid === 1'h1)
    begin
      got = notes.pop_front();
      check({cycle_dest, cycle_write_blocked, extended_smm_access_error} === got, "steering");
    end
  end

  // main sequence: every upper and lower field code with graphics mode 0 and 1, then lock and reset behaviour
  initial
  begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'h1;
    rd(8'h70, 8'h00);
    rd(8'h71, 8'h00);
    for (int g = 0; g < 2; g++)
      for (int u = 0; u < 4; u++)
        for (int l = 0; l < 4; l++)
        begin
          cur_reg = {g[1:0], u[1:0], l[1:0], 2'h0};
          seed = lfsr_next(seed);
          wr(8'h70, cur_reg | 8'h01);
          top_of_memory <= g[0] ? 32'h10000000 : 32'h08000000;
          err_model = 1'h0;
          @(negedge ref_clk);
          check(graphics_mode_select === g[1:0], "mode field");
          sz = cur_reg[4] ? smm_window_pkg::TOP_SIZE_1M : smm_window_pkg::TOP_SIZE_512K;
          issue(smm_window_pkg::AB_SEG_BASE + {seed, 9'h000}, 5'h1A);
          issue(smm_window_pkg::AB_SEG_BASE + {seed, 9'h100}, 5'h12);
          issue(smm_window_pkg::AB_SEG_LAST - {seed, 8'h00}, 5'h02);
          issue(smm_window_pkg::AB_SEG_BASE + {seed, 9'h004}, 5'h06);
          issue(smm_window_pkg::AB_SEG_LAST, 5'h14);
          issue(smm_window_pkg::HIGH_REMAP_BASE, 5'h12);
          issue(smm_window_pkg::HIGH_REMAP_LAST, 5'h02);
          issue(top_of_memory - sz, 5'h07);
          issue(top_of_memory - sz, 5'h12);
          issue(top_of_memory - sz - 32'h00000001, 5'h02);
          issue(top_of_memory - 32'h00000001, 5'h02);
          issue(top_of_memory, 5'h02);
          host_bus_model_inst.release_bus();
          rd(8'h70, cur_reg | {7'h00, err_model});
        end
    wr(8'h70, 8'h4D);
    err_model = 1'h0;
    wr(8'h70, 8'h4E);
    rd(8'h70, 8'h4E);
    check(row_population_read_only === 1'h1, "row lock");
    wr(8'h70, 8'hB0);
    rd(8'h70, 8'h4A);
    wr(8'h72, 8'hFF);
    rd(8'h70, 8'h4A);
    cur_reg = 8'h48;
    issue(smm_window_pkg::AB_SEG_BASE, 5'h1A);
    host_bus_model_inst.release_bus();
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'h0;
    @(posedge ref_clk);
    rst_n <= 1'h1;
    rd(8'h70, 8'h00);
    check(row_population_read_only === 1'h0, "row lock after reset");
    wr(8'h70, 8'h06);
    wr(8'h70, 8'h0A);
    rd(8'h70, 8'h06);
    check(notes.size() == 0, "results missing");
    tally_and_finish;
  end

  // hang guard, far beyond the expected run length
  initial
  begin
    #100000;
    err_total++;
    tally_and_finish;
  end
endmodule
